// File: rtl/isp_host.sv
// Host controller driving a device's serial programming port
// Function
// R1 - Target reset held low throughout the programming session.
// R2 - Programming-enable sent first after reset falls, before any other instruction.
// R3 - Device auto-erases EEPROM bytes; host needs no erase before EEPROM write.
// R4 - Chip erase sets flash and EEPROM to all ones.
// R5 - Flash word addresses 0 to 3FF, EEPROM byte addresses 0 to 3F; flash frames carry only cmd_addr[9] and cmd_addr[7:0], so 512 words.
// R6 - Serial clock low over one and high over four device clocks.
// R7 - Power-up with reset and serial clock low; pulse reset if unsure.
// R8 - Wait at least 20 ms after power-up before programming-enable.
// R9 - After chip erase wait 10 ms, pulse reset, re-enable programming.
// R10 - One byte per write instruction; wait 4 ms before next write.
// R11 - Read instruction returns stored byte on serial output.
// R12 - Releasing reset high ends the session; device runs normally.
// R13 - Power-off: device clock low, then reset high.
// R14 - Programming-enable is AC, 53, two don't-care bytes.
// R15 - Chip erase is AC then second byte beginning 100.
// R16 - Flash read: 0010H000, high address bit, low address, data returned.
// R17 - Flash write: 0100H000, same address fields, data in byte four.
// R18 - EEPROM read: A0, zero, six-bit address, data returned.
// R19 - EEPROM write: C0, zero, six-bit address, data byte.
// R20 - Lock write: AC, second byte 111xx21x, zero programs lock bit.
// R21 - Device code read: 30, don't care, two-bit index, code returned.
// R22 - Device samples on rising serial clock, shifts out on falling.
// R23 - 32-bit frames MSB first; read data during the fourth byte.
module isp_host
    import isp_pkg::*;
#(
    parameter int unsigned POWERUP_WAIT = POWERUP_CYC,
    parameter int unsigned ERASE_WAIT   = ERASE_CYC,
    parameter int unsigned WRITE_WAIT   = WRITE_CYC,
    parameter int unsigned RESET_WAIT   = RESET_PULSE_CYC
) (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [2:0]  cmd_op,
    input  wire logic [9:0]  cmd_addr,
    input  wire logic        cmd_high,
    input  wire logic [7:0]  cmd_data,
    output logic             rd_valid,
    input  wire logic        rd_ready,
    output logic [7:0]       rd_data,
    output logic             busy,
    output logic             target_reset_n,
    output logic             sck_out,
    output logic             mosi_out,
    input  wire logic        miso_in
);
    // ==========================================================
    // State
    typedef enum logic [7:0] {
        ST_POWERUP = 8'h01,
        ST_ENABLE  = 8'h02,
        ST_IDLE    = 8'h04,
        ST_SHIFT   = 8'h08,
        ST_WAIT    = 8'h10,
        ST_RST_HI  = 8'h20,
        ST_RST_LO  = 8'h40,
        ST_DONE    = 8'h80
    } state_t;

    state_t                 state_q;
    logic [CNT_W-1:0]       wait_q;
    logic [3:0]             div_q;
    logic [BIT_CNT_W-1:0]   bit_q;
    logic [FRAME_BITS-1:0]  tx_q;
    logic [BYTE_W-1:0]      rx_q;
    logic                   sck_q;
    logic                   rst_n_q;
    logic                   is_read_q;
    logic                   is_erase_q;
    logic                   is_write_q;
    logic                   miso_s1_q;
    logic                   miso_s2_q;
    logic [FRAME_BITS-1:0]  frame_d;
    logic                   fifo_in_valid;
    logic                   fifo_in_ready;
    logic                   cmd_take;
    cmd_t                   op;

    assign op = cmd_t'(cmd_op);

    // ==========================================================
    // Pin input synchroniser
    always_ff @(posedge clock) begin
        if (srst) begin
            miso_s1_q <= 1'b0;
            miso_s2_q <= 1'b0;
        end else if (ce) begin
            miso_s1_q <= miso_in;
            miso_s2_q <= miso_s1_q;
        end
    end

    // ==========================================================
    // Frame builder
    always_comb begin
        frame_d = {OP_PROG_EN, OP_ERASE_B2, ZERO_BYTE, ZERO_BYTE}; // R15
        case (op)
            CMD_FLASH_RD: frame_d = {OP_FLASH_RD | (BYTE_W'(cmd_high) << HIGH_SEL_BIT), // R16
                                     7'h00, cmd_addr[9], cmd_addr[7:0], ZERO_BYTE}; // R5
            CMD_FLASH_WR: frame_d = {OP_FLASH_WR | (BYTE_W'(cmd_high) << HIGH_SEL_BIT), // R17
                                     7'h00, cmd_addr[9], cmd_addr[7:0], cmd_data}; // R10
            CMD_EE_RD:    frame_d = {OP_EE_RD, ZERO_BYTE,
                                     cmd_addr[7:0] & EE_ADDR_MASK, ZERO_BYTE}; // R18
            CMD_EE_WR:    frame_d = {OP_EE_WR, ZERO_BYTE,
                                     cmd_addr[7:0] & EE_ADDR_MASK, cmd_data}; // R19 R3
            CMD_LOCK_WR:  frame_d = {OP_PROG_EN, OP_LOCK_B2 | (cmd_data & LOCK_KEEP_MASK),
                                     ZERO_BYTE, ZERO_BYTE}; // R20
            CMD_CODE_RD:  frame_d = {OP_CODE_RD, ZERO_BYTE,
                                     cmd_addr[7:0] & CODE_IDX_MASK, ZERO_BYTE}; // R21
            default:      frame_d = {OP_PROG_EN, OP_ERASE_B2, ZERO_BYTE, ZERO_BYTE};
        endcase
    end

    // Commands are taken only while the FIFO has room, so a full FIFO stalls commands
    assign cmd_ready = (state_q == ST_IDLE) && fifo_in_ready;
    assign cmd_take  = cmd_valid && cmd_ready && ce;
    assign busy      = (state_q != ST_IDLE);

    // ==========================================================
    // Sequencer
    always_ff @(posedge clock) begin
        if (srst) begin
            state_q    <= ST_POWERUP;
            wait_q     <= '0;
            div_q      <= '0;
            bit_q      <= '0;
            tx_q       <= '0;
            rx_q       <= '0;
            sck_q      <= 1'b0;
            rst_n_q    <= 1'b0; // R7
            is_read_q  <= 1'b0;
            is_erase_q <= 1'b0;
            is_write_q <= 1'b0;
        end else if (ce) begin
            case (state_q)
                ST_POWERUP: begin
                    sck_q <= 1'b0;
                    if (wait_q == CNT_W'(POWERUP_WAIT - 1)) begin // R8
                        wait_q  <= '0;
                        state_q <= ST_ENABLE;
                    end else begin
                        wait_q <= wait_q + CNT_W'(1);
                    end
                end
                ST_ENABLE: begin
                    // Enable frame must precede every other frame
                    tx_q       <= {OP_PROG_EN, OP_PROG_EN_B2, ZERO_BYTE, ZERO_BYTE}; // R2 R14
                    is_read_q  <= 1'b0;
                    is_erase_q <= 1'b0;
                    is_write_q <= 1'b0;
                    bit_q      <= '0;
                    div_q      <= '0;
                    state_q    <= ST_SHIFT;
                end
                ST_IDLE: begin
                    if (cmd_take) begin
                        if (op == CMD_END) begin
                            rst_n_q <= 1'b1; // R12 R13
                            state_q <= ST_DONE;
                        end else begin
                            tx_q       <= frame_d;
                            is_read_q  <= (op == CMD_FLASH_RD) || (op == CMD_EE_RD)
                                          || (op == CMD_CODE_RD);
                            is_erase_q <= (op == CMD_ERASE);
                            is_write_q <= (op == CMD_FLASH_WR) || (op == CMD_EE_WR)
                                          || (op == CMD_LOCK_WR);
                            bit_q      <= '0;
                            div_q      <= '0;
                            state_q    <= ST_SHIFT;
                        end
                    end
                end
                ST_SHIFT: begin
                    // Divider keeps each half period well over four device clocks
                    if (!sck_q) begin
                        if (div_q == 4'(SCK_LOW_CYC - 1)) begin // R6
                            div_q <= '0;
                            sck_q <= 1'b1;
                            // Device drives on falling edge, so it is stable here
                            rx_q  <= {rx_q[BYTE_W-2:0], miso_s2_q}; // R22 R11
                        end else begin
                            div_q <= div_q + 4'(1);
                        end
                    end else begin
                        if (div_q == 4'(SCK_HIGH_CYC - 1)) begin // R6
                            div_q <= '0;
                            sck_q <= 1'b0;
                            tx_q  <= {tx_q[FRAME_BITS-2:0], 1'b0}; // R23
                            if (bit_q == BIT_CNT_W'(FRAME_BITS - 1)) begin
                                wait_q  <= '0;
                                state_q <= ST_WAIT;
                            end else begin
                                bit_q <= bit_q + BIT_CNT_W'(1);
                            end
                        end else begin
                            div_q <= div_q + 4'(1);
                        end
                    end
                end
                ST_WAIT: begin
                    if (is_erase_q) begin
                        if (wait_q == CNT_W'(ERASE_WAIT - 1)) begin // R9
                            wait_q  <= '0;
                            rst_n_q <= 1'b1;
                            state_q <= ST_RST_HI;
                        end else begin
                            wait_q <= wait_q + CNT_W'(1);
                        end
                    end else if (is_write_q) begin
                        if (wait_q == CNT_W'(WRITE_WAIT - 1)) begin // R10
                            state_q <= ST_IDLE;
                        end else begin
                            wait_q <= wait_q + CNT_W'(1);
                        end
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_RST_HI: begin
                    if (wait_q == CNT_W'(RESET_WAIT - 1)) begin // R9
                        wait_q  <= '0;
                        rst_n_q <= 1'b0; // R1
                        state_q <= ST_RST_LO;
                    end else begin
                        wait_q <= wait_q + CNT_W'(1);
                    end
                end
                ST_RST_LO: begin
                    if (wait_q == CNT_W'(RESET_WAIT - 1)) begin
                        wait_q  <= '0;
                        state_q <= ST_ENABLE; // R9
                    end else begin
                        wait_q <= wait_q + CNT_W'(1);
                    end
                end
                ST_DONE: begin
                    sck_q <= 1'b0;
                end
                default: begin
                    state_q <= ST_POWERUP;
                end
            endcase
        end
    end

    assign fifo_in_valid  = ce && (state_q == ST_WAIT) && is_read_q;
    assign target_reset_n = rst_n_q;
    assign sck_out        = sck_q;
    assign mosi_out       = tx_q[FRAME_BITS-1]; // R23

    // ==========================================================
    // Read-result buffer
    isp_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .srst      (srst),
        .ce        (ce),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_q),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );
endmodule

// File: rtl/isp_pkg.sv
// Package of constants for the serial programming host controller
package isp_pkg;
    localparam int unsigned CLK_PERIOD_NS   = 10;
    // Link clock derived by divider: half periods in system clocks
    localparam int unsigned SCK_LOW_CYC     = 8;
    localparam int unsigned SCK_HIGH_CYC    = 8;
    localparam int unsigned CNT_W           = 24;
    // Waits in their own units
    localparam int unsigned POWERUP_MS      = 20;
    localparam int unsigned ERASE_MS        = 10;
    localparam int unsigned WRITE_MS        = 4;
    localparam int unsigned RESET_PULSE_US  = 100;
    localparam int unsigned POWERUP_CYC     = POWERUP_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned ERASE_CYC       = ERASE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned WRITE_CYC       = WRITE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned RESET_PULSE_CYC = RESET_PULSE_US * 1000 / CLK_PERIOD_NS;
    // Frame layout
    localparam int unsigned FRAME_BITS      = 32;
    localparam int unsigned BIT_CNT_W       = 6;
    localparam int unsigned BYTE_W          = 8;
    // Instruction bytes, field masks and address widths
    localparam logic [7:0] OP_PROG_EN      = 8'hAC;
    localparam logic [7:0] OP_PROG_EN_B2   = 8'h53;
    localparam logic [7:0] OP_ERASE_B2     = 8'h80;
    localparam logic [7:0] OP_LOCK_B2      = 8'hE0;
    localparam logic [7:0] OP_FLASH_RD     = 8'h20;
    localparam logic [7:0] OP_FLASH_WR     = 8'h40;
    localparam logic [7:0] OP_EE_RD        = 8'hA0;
    localparam logic [7:0] OP_EE_WR        = 8'hC0;
    localparam logic [7:0] OP_CODE_RD      = 8'h30;
    localparam int unsigned HIGH_SEL_BIT   = 3;
    localparam logic [7:0] LOCK_KEEP_MASK  = 8'h06;
    localparam logic [7:0] EE_ADDR_MASK    = 8'h3F;
    localparam logic [7:0] CODE_IDX_MASK   = 8'h03;
    localparam logic [7:0] ZERO_BYTE       = 8'h00;
    localparam logic [7:0] ERASED_BYTE     = 8'hFF;
    localparam int unsigned FLASH_ADDR_W   = 10;
    localparam int unsigned EE_ADDR_W      = 6;
    // Host commands
    typedef enum logic [2:0] {
        CMD_ERASE      = 3'h0,
        CMD_FLASH_RD   = 3'h1,
        CMD_FLASH_WR   = 3'h2,
        CMD_EE_RD      = 3'h3,
        CMD_EE_WR      = 3'h4,
        CMD_LOCK_WR    = 3'h5,
        CMD_CODE_RD    = 3'h6,
        CMD_END        = 3'h7
    } cmd_t;
    localparam int unsigned FIFO_DEPTH     = 4;
    localparam int unsigned FIFO_W         = 8;
endpackage

// File: rtl/isp_fifo.sv
// Small flip-flop FIFO for read results
module isp_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (ce && push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (ce) begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// File: sim/isp_host_assertions.sv
// Checker for the host's link and command ports
module isp_host_checker
    import isp_pkg::*;
(
    input wire logic       clock,
    input wire logic       srst,
    input wire logic       ce,
    input wire logic       cmd_valid,
    input wire logic       cmd_ready,
    input wire logic [2:0] cmd_op,
    input wire logic       rd_valid,
    input wire logic       rd_ready,
    input wire logic [7:0] rd_data,
    input wire logic       busy,
    input wire logic       target_reset_n,
    input wire logic       sck_out,
    input wire logic       mosi_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    logic take;
    assign take = cmd_valid && cmd_ready && ce;
    // ==========
    // Link pins
    a_reset_pins_low: assert property (
        disable iff (1'b0) srst |=> !sck_out && !target_reset_n) else $error("Pins not low");
    a_sck_high_hold: assert property (
        $rose(sck_out) |-> sck_out [*8] ##1 !sck_out) else $error("Short clock high");
    a_sck_low_hold: assert property (
        $fell(sck_out) |-> (!sck_out) [*2]) else $error("Short clock low");
    a_mosi_on_low: assert property (
        $changed(mosi_out) |-> !sck_out) else $error("Data moved while clock high");
    a_reset_in_frame: assert property (
        sck_out |-> !target_reset_n) else $error("Clock with target out of reset");
    // ==========
    // Commands
    a_frame_start: assert property (
        take && cmd_op != CMD_END |=> busy ##0 (!sck_out) [*8] ##1 sck_out)
        else $error("Frame start late");
    a_end_release: assert property (
        take && cmd_op == CMD_END |=> target_reset_n) else $error("Reset not released");
    a_one_at_time: assert property (
        cmd_ready |-> !busy) else $error("Ready while busy");
    a_read_holds: assert property (
        rd_valid && !rd_ready |=> rd_valid && $stable(rd_data)) else $error("Result lost");
    c_erase: cover property (take && cmd_op == CMD_ERASE);
    c_read: cover property (rd_valid && rd_ready);
    c_end: cover property ($rose(target_reset_n));
endmodule

bind isp_host isp_host_checker u_chk (.clock, .srst, .ce, .cmd_valid, .cmd_ready, .cmd_op,
    .rd_valid, .rd_ready, .rd_data, .busy, .target_reset_n, .sck_out, .mosi_out);

// File: sim/isp_dev.sv
// Behavioural target: serial programming port with flash, EEPROM and codes
module isp_dev #(
    parameter logic [31:0] CODES  = 32'h0000_0000,
    parameter int          PWR_NS = 0,
    parameter int          ER_NS  = 0,
    parameter int          WR_NS  = 0
) (
    input  wire logic rst_n,
    input  wire logic sck,
    input  wire logic mosi,
    output logic      miso
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] flash [512];
    logic [7:0]  ee [64];
    logic [31:0] sh;
    logic [7:0]  rd, b1, b2, b3, b4;
    logic [1:0]  lock_q = 2'b11;
    logic        en_q = 1'b0;
    logic        ok = 1'b0;
    logic        miso_q = 1'b0;
    int          cnt = 0;
    realtime     t_free = 0;
    assign miso = miso_q;
    // Unerased flash reads zero, so a skipped erase shows up
    initial foreach (flash[i]) flash[i] = 16'h0000;
    initial foreach (ee[i]) ee[i] = 8'h00;
    function automatic logic [7:0] fetch();
        if (!en_q) return 8'h00;
        if ({b1[7:4], b1[2:0]} == 7'h10 && b2[7:1] == 7'h00)
            return flash[{b2[0], b3}][b1[3]*8 +: 8];
        if (b1 == 8'hA0 && b2 == 8'h00) return ee[b3[5:0]];
        if (b1 == 8'h30) return CODES[8*(3-b3[1:0]) +: 8];
        return 8'h00;
    endfunction
    task automatic exec();
        if (b1 == 8'hAC && b2 == 8'h53 && $realtime >= PWR_NS) begin
            en_q = 1'b1;
        end else if (en_q && b1 == 8'hAC && b2[7:5] == 3'b100) begin
            foreach (flash[i]) flash[i] = 16'hFFFF;
            foreach (ee[i]) ee[i] = 8'hFF;
            lock_q = 2'b11;
            t_free = $realtime + ER_NS;
        end else if (en_q && b1 == 8'hAC && b2[7:5] == 3'b111) begin
            lock_q &= b2[2:1];
        end else if (en_q && {b1[7:4], b1[2:0]} == 7'h20 && b2[7:1] == 7'h00) begin
            flash[{b2[0], b3}][b1[3]*8 +: 8] &= b4;
            t_free = $realtime + WR_NS;
        end else if (en_q && b1 == 8'hC0 && b2 == 8'h00) begin
            ee[b3[5:0]] = b4;
            t_free = $realtime + WR_NS;
        end
    endtask
    // Releasing reset leaves programming mode
    always @(posedge rst_n) begin
        en_q = 1'b0;
        cnt = 0;
    end
    always @(posedge sck) begin
        if (!rst_n) begin
            if (cnt == 0) ok = ($realtime >= t_free);
            sh = {sh[30:0], mosi};
            cnt++;
            if (cnt == 24) begin
                {b1, b2, b3} = sh[23:0];
                rd = fetch();
            end
            if (cnt == 32) begin
                cnt = 0;
                {b1, b2, b3, b4} = sh;
                if (ok) exec();
            end
        end
    end
    // Outside byte four the line toggles, never a stale level
    always @(negedge sck) miso_q <= (!rst_n && cnt >= 24) ? rd[31-cnt] : ~miso_q;
endmodule

// File: sim/serial_program_download_bench.sv
// Bench for the serial programming host against a behavioural target
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module serial_program_download_bench;
    import isp_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] DEV_CODES = 32'h5AC3_96E1; // Arbitrary code bytes
    logic       clock = 1'b0, srst = 1'b1, ce = 1'b1, cmd_valid = 1'b0;
    logic       cmd_high = 1'b0, rd_ready = 1'b1;
    logic [2:0] cmd_op = 3'h0;
    logic [9:0] cmd_addr = 10'h000;
    logic [7:0] cmd_data = 8'h00, m, d;
    logic [7:0] exp_q [$];
    logic [15:0] fl_e [512];
    logic [7:0] ee_e [64];
    logic [8:0] w;
    logic [5:0] ea;
    logic       cmd_ready, rd_valid, busy, target_reset_n, sck_out, mosi_out, miso;
    logic [7:0] rd_data;
    int         bad_count = 0, n_checks = 0;
    always #5 clock = ~clock;
    localparam int PWR_W = 300;
    localparam int ER_W  = 200;
    localparam int WR_W  = 100;
    localparam int RST_W = 20;
    isp_host #(.POWERUP_WAIT(PWR_W), .ERASE_WAIT(ER_W), .WRITE_WAIT(WR_W),
        .RESET_WAIT(RST_W)) dut (
        .clock(clock), .srst(srst), .ce(ce), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_high(cmd_high), .cmd_data(cmd_data),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .busy(busy),
        .target_reset_n(target_reset_n), .sck_out(sck_out), .mosi_out(mosi_out),
        .miso_in(miso));
    // Target timing equals the host's power-up, erase and write waits; the reset pulse wait is not modelled
    isp_dev #(.CODES(DEV_CODES), .PWR_NS(PWR_W * CLK_PERIOD_NS),
        .ER_NS(ER_W * CLK_PERIOD_NS), .WR_NS(WR_W * CLK_PERIOD_NS)) dev (
        .rst_n(target_reset_n), .sck(sck_out), .mosi(mosi_out), .miso(miso));
    task automatic send(input cmd_t op, input logic [9:0] a, input logic h, input logic [7:0] v);
        @(posedge clock);
        #1;
        {cmd_valid, cmd_op, cmd_addr, cmd_high, cmd_data} = {1'b1, op, a, h, v};
        for (int i = 0; i < 8000 && cmd_ready !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        if (cmd_ready !== 1'b1) bad_count++;
        @(posedge clock);
        #1 cmd_valid = 1'b0;
    endtask
    task automatic rd(input cmd_t op, input logic [9:0] a, input logic h, input logic [7:0] e);
        exp_q.push_back(e);
        send(op, a, h, 8'h00);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 8000 && busy !== 1'b0; i++) begin
            @(posedge clock);
            #1;
        end
        if (busy !== 1'b0) bad_count++;
    endtask
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ==========
    // Result scoreboard, sampled mid-cycle where handshake is settled
    always @(negedge clock) begin
        if (rd_valid === 1'b1 && rd_ready === 1'b1 && ce === 1'b1) begin
            m = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
            `CHK(rd_data, m)
        end
    end
    initial begin
        #400000;
        bad_count++;
        $display("Watchdog expired");
        test_done();
    end
    // ==========
    // Main sequence
    initial begin
        void'($urandom(32'h27D3D035));
        repeat (12) @(posedge clock);
        #1 srst = 1'b0;
        wait_idle();
        `CHK(dev.en_q, 1'b1)
        send(CMD_ERASE, 10'h000, 1'b0, 8'h00);
        foreach (fl_e[i]) fl_e[i] = 16'hFFFF;
        foreach (ee_e[i]) ee_e[i] = 8'hFF;
        w = 9'($urandom);
        ea = 6'($urandom);
        for (int k = 0; k < 2; k++) begin
            d = 8'($urandom);
            send(CMD_FLASH_WR, {w[8], 1'b0, w[7:0]}, k[0], d);
            fl_e[w][k*8 +: 8] = d;
            d = 8'($urandom);
            send(CMD_EE_WR, {4'h0, ea}, 1'b0, d);
            ee_e[ea] = d;
        end
        // Freeze inside the write wait; the wait must resume, not finish early
        repeat (560) @(posedge clock);
        #1 ce = 1'b0;
        repeat (60 + $urandom % 8) @(posedge clock);
        #1 `CHK({busy, sck_out, mosi_out, target_reset_n}, 4'h8)
        ce = 1'b1;
        $display("Test freeze done");
        for (int k = 0; k < 2; k++) begin
            rd(CMD_FLASH_RD, {w[8], 1'b0, w[7:0]}, k[0], fl_e[w][k*8 +: 8]);
        end
        rd(CMD_FLASH_RD, {~w[8], 1'b0, w[7:0]}, 1'b1, 8'hFF);
        rd(CMD_EE_RD, {4'h0, ea}, 1'b0, ee_e[ea]);
        rd(CMD_EE_RD, {4'h0, ~ea}, 1'b0, 8'hFF);
        for (int k = 0; k < 4; k++) rd(CMD_CODE_RD, 10'(k), 1'b0, DEV_CODES[31-8*k -: 8]);
        send(CMD_LOCK_WR, 10'h000, 1'b0, 8'h04);
        wait_idle();
        `CHK(dev.lock_q, 2'b10)
        $display("Test access done");
        rd_ready = 1'b0;
        for (int k = 0; k < 4; k++) rd(CMD_EE_RD, {4'h0, ea + 6'(k)}, 1'b0, ee_e[ea + 6'(k)]);
        wait_idle();
        `CHK(cmd_ready, 1'b0)
        `CHK(rd_valid, 1'b1)
        rd_ready = 1'b1;
        repeat (8) @(posedge clock);
        #1 `CHK(rd_valid, 1'b0)
        $display("Test buffer done");
        send(CMD_END, 10'h000, 1'b0, 8'h00);
        repeat (2) @(posedge clock);
        #1 `CHK(target_reset_n, 1'b1)
        `CHK(dev.en_q, 1'b0)
        `CHK(exp_q.size(), 0)
        $display("Test end done");
        test_done();
    end
endmodule
